// ===== verilog/lvh_pkg.sv
`default_nettype none
package lvh_pkg;
  localparam int unsigned CLK_MHZ = 200;
  // Timebase tick for delays and cycle counters
  localparam int unsigned TICK_MS = 100;
  localparam int unsigned TICK_CYC = TICK_MS * 1000 * CLK_MHZ;
  localparam int unsigned CYC_BASE_S = 10;
  localparam int unsigned CYC_BASE_TICKS = CYC_BASE_S * 1000 / TICK_MS;
  localparam int unsigned VAL_W = 16;
  localparam logic [15:0] CO2_RANGE = 16'h07D0;
  localparam logic [15:0] HUM_RANGE = 16'h0064;
  localparam logic [1:0] EXT_NONE = 2'h0;
  localparam logic [1:0] EXT_ABS = 2'h1;
  localparam logic [1:0] EXT_PCT = 2'h2;
  localparam logic [1:0] EXT_TEACH = 2'h3;
  localparam logic OBJ_RST = 1'h0;
endpackage
`default_nettype wire

// ===== verilog/lvh_monitor.sv
// How it works
// - Four carbon dioxide and two humidity channels, each enabled separately.
// - Configured threshold loads at initialisation and on every download.
// - Configured threshold stays until an external value replaces it.
// - Each channel has its own hysteresis and direction response.
// - Below-sets-on: 1 below threshold, 0 only above threshold plus hysteresis.
// - Zero hysteresis toggles the output on every threshold crossing.
// - A no-telegram state sends nothing and halts cycling until the opposite state.
// - Cyclic interval is cycle factor times ten seconds.
// - Undershooting again sends ON anew and resumes its cyclic repetition.
// - Threshold writable as 2-byte absolute or 1-byte percentage value.
// - Teach value 1 copies latest measurement into threshold; 0 ignored.
// - External or taught threshold stays until a later external value or a download.
// - Download discards external thresholds and restores configured ones.
// - Delays gate both on-change and cyclic transmissions.
// - Rising result uses switch-on delay, falling uses switch-off delay.
// - Without delay the delayed state follows the comparator at once.
// - With delay a timer runs; only on expiry state changes and sends.
// - Reverting before expiry stops the timer, keeps state, sends nothing.
// - Hysteresis band outside the range lets the state change only once.
// - On-change enabled sends the state on every transition, except into a no-telegram state.
// - Cycle factor zero disables cyclic transmission.
// - On-change telegrams never restart the cyclic period.
`timescale 1ns/1ps
`default_nettype none
module lvh_monitor #(
  parameter int unsigned N_CO2 = 4,
  parameter int unsigned N_HUM = 2,
  parameter int unsigned TICK_CYC = lvh_pkg::TICK_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cfg_load_i,
  input wire logic [15:0] co2_val_i,
  input wire logic co2_valid_i,
  input wire logic [15:0] hum_val_i,
  input wire logic hum_valid_i,
  input wire logic [N_CO2+N_HUM-1:0] ch_en_i,
  input wire logic [N_CO2+N_HUM-1:0][15:0] cfg_thr_i,
  input wire logic [N_CO2+N_HUM-1:0][15:0] cfg_hyst_i,
  input wire logic [N_CO2+N_HUM-1:0] below_threshold_sets_on_i,
  input wire logic [N_CO2+N_HUM-1:0] tel_on_i,
  input wire logic [N_CO2+N_HUM-1:0] tel_off_i,
  input wire logic [N_CO2+N_HUM-1:0] chg_send_i,
  input wire logic [N_CO2+N_HUM-1:0][7:0] cyc_factor_i,
  input wire logic [N_CO2+N_HUM-1:0][7:0] on_dly_i,
  input wire logic [N_CO2+N_HUM-1:0][7:0] off_dly_i,
  input wire logic [N_CO2+N_HUM-1:0][1:0] ext_mode_i,
  input wire logic [N_CO2+N_HUM-1:0] ext_wr_i,
  input wire logic [15:0] ext_val_i,
  output logic [N_CO2+N_HUM-1:0] tel_valid_o,
  output logic [N_CO2+N_HUM-1:0] tel_val_o,
  output logic [N_CO2+N_HUM-1:0][15:0] threshold_level_o
);
  localparam int unsigned N = N_CO2 + N_HUM;
  localparam int unsigned PW = $clog2(TICK_CYC + 1);

  typedef struct packed {
    logic loaded;
    logic [PW-1:0] pre;
    logic tick;
    logic [N-1:0][15:0] thr;
    logic [N-1:0] raw;
    logic [N-1:0] dly;
    logic [N-1:0][7:0] tmr;
    logic [N-1:0][14:0] cyc;
    logic [N-1:0] tv;
    logic [N-1:0] tval;
  } lvh_state_t;

  lvh_state_t s;
  lvh_state_t next_s;

  // Low channel indices belong to the carbon dioxide quantity
  function automatic logic is_co2(input int idx);
    return idx < int'(N_CO2);
  endfunction

  always_comb
  begin
    logic [15:0] meas;
    logic mv;
    logic [15:0] rng;
    logic [16:0] m17;
    logic [16:0] t17;
    logic [16:0] hi;
    logic [16:0] lo;
    logic [7:0] d;
    logic [14:0] per;
    meas = 16'h0000;
    mv = 1'b0;
    rng = 16'h0000;
    m17 = 17'h00000;
    t17 = 17'h00000;
    hi = 17'h00000;
    lo = 17'h00000;
    d = 8'h00;
    per = 15'h0000;
    next_s = s;
    next_s.tv = '0;
    next_s.loaded = 1'b1;
    next_s.tick = (s.pre == PW'(TICK_CYC - 1));
    next_s.pre = next_s.tick ? '0 : s.pre + 1'b1;
    for (int i = 0; i < N; i++)
    begin
      // Channels below N_CO2 watch the carbon dioxide value
      meas = is_co2(i) ? co2_val_i : hum_val_i;
      mv = is_co2(i) ? co2_valid_i : hum_valid_i;
      rng = is_co2(i) ? lvh_pkg::CO2_RANGE : lvh_pkg::HUM_RANGE;
      m17 = {1'b0, meas};
      t17 = {1'b0, s.thr[i]};
      // Band edges are not clipped to the range: a band past it never releases
      hi = t17 + {1'b0, cfg_hyst_i[i]};
      lo = t17 - {1'b0, cfg_hyst_i[i]};
      d = s.raw[i] ? on_dly_i[i] : off_dly_i[i];
      per = 15'(cyc_factor_i[i]) * 15'(lvh_pkg::CYC_BASE_TICKS);
      if (!s.loaded || cfg_load_i)
      begin
        next_s.thr[i] = cfg_thr_i[i];
        next_s.raw[i] = lvh_pkg::OBJ_RST;
        next_s.dly[i] = lvh_pkg::OBJ_RST;
        next_s.tmr[i] = 8'h00;
        next_s.cyc[i] = 15'h0000;
      end
      else if (!ch_en_i[i])
      begin
        next_s.raw[i] = lvh_pkg::OBJ_RST;
        next_s.dly[i] = lvh_pkg::OBJ_RST;
        next_s.tmr[i] = 8'h00;
        next_s.cyc[i] = 15'h0000;
      end
      else
      begin
        // Threshold changes only by an external write
        if (ext_wr_i[i])
        begin
          case (ext_mode_i[i])
            lvh_pkg::EXT_ABS: next_s.thr[i] = ext_val_i;
            lvh_pkg::EXT_PCT: next_s.thr[i] = 16'((24'(ext_val_i[7:0]) * 24'(rng)) >> 8);
            lvh_pkg::EXT_TEACH:
            begin
              if (ext_val_i[0])
                next_s.thr[i] = meas;
            end
            default: ;
          endcase
        end
        if (mv)
        begin
          // Comparator runs on each fresh sample only
          if (below_threshold_sets_on_i[i])
          begin
            if (m17 < t17)
              next_s.raw[i] = 1'b1;
            else if (m17 > hi)
              next_s.raw[i] = 1'b0;
          end
          else
          begin
            if (m17 > t17)
              next_s.raw[i] = 1'b1;
            else if (cfg_hyst_i[i] <= s.thr[i] && m17 < lo)
              next_s.raw[i] = 1'b0;
          end
        end
        if (s.raw[i] == s.dly[i])
          next_s.tmr[i] = 8'h00;
        else if (d == 8'h00 || (s.tmr[i] == 8'h01 && s.tick))
        begin
          next_s.dly[i] = s.raw[i];
          next_s.tmr[i] = 8'h00;
          if (chg_send_i[i] && (s.raw[i] ? tel_on_i[i] : tel_off_i[i]))
            next_s.tv[i] = 1'b1;
        end
        else if (s.tmr[i] == 8'h00)
          next_s.tmr[i] = d;
        else if (s.tick)
          next_s.tmr[i] = s.tmr[i] - 8'h01;
        // Cycle counter is never touched by on-change sends
        if (per == 15'h0000)
          next_s.cyc[i] = 15'h0000;
        else if (s.tick)
        begin
          if (s.cyc[i] >= per - 15'h0001)
          begin
            next_s.cyc[i] = 15'h0000;
            // Permission is taken from the value actually sent, which may commit this cycle
            if (next_s.dly[i] ? tel_on_i[i] : tel_off_i[i])
              next_s.tv[i] = 1'b1;
          end
          else
            next_s.cyc[i] = s.cyc[i] + 15'h0001;
        end
      end
      next_s.tval[i] = next_s.tv[i] ? next_s.dly[i] : s.tval[i];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      s <= '0;
    else
      s <= next_s;
  end

  assign tel_valid_o = s.tv;
  assign tel_val_o = s.tval;
  assign threshold_level_o = s.thr;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  logic run0;
  logic run1;
  logic run3;
  logic run4;
  assign run0 = s.loaded && !cfg_load_i && ch_en_i[0];
  assign run1 = s.loaded && !cfg_load_i && ch_en_i[1];
  assign run3 = s.loaded && !cfg_load_i && ch_en_i[3];
  assign run4 = s.loaded && !cfg_load_i && ch_en_i[4];

  a_load_thr: assert property (cfg_load_i |=> s.thr[0] == $past(cfg_thr_i[0]))
    else $error("configured threshold not loaded");
  a_thr_hold: assert property (s.loaded && !cfg_load_i && !ext_wr_i[0] |=> $stable(s.thr[0]))
    else $error("threshold changed without a write");
  a_ext_abs: assert property (run0 && ext_wr_i[0] && ext_mode_i[0] == lvh_pkg::EXT_ABS
    |=> s.thr[0] == $past(ext_val_i))
    else $error("absolute threshold not taken");
  a_teach_zero: assert property (run0 && ext_wr_i[0] && ext_mode_i[0] == lvh_pkg::EXT_TEACH && !ext_val_i[0]
    |=> $stable(s.thr[0]))
    else $error("teach value 0 changed threshold");
  a_below_on: assert property (run0 && co2_valid_i && below_threshold_sets_on_i[0] && co2_val_i < s.thr[0]
    |=> s.raw[0])
    else $error("undershoot did not set comparator");
  a_band_off: assert property (run0 && co2_valid_i && below_threshold_sets_on_i[0]
    && {1'b0, co2_val_i} > {1'b0, s.thr[0]} + {1'b0, cfg_hyst_i[0]} |=> !s.raw[0])
    else $error("band exceed did not clear comparator");
  a_no_delay: assert property (run0 && s.raw[0] != s.dly[0] && (s.raw[0] ? on_dly_i[0] : off_dly_i[0]) == 8'h00
    |=> s.dly[0] == $past(s.raw[0]))
    else $error("undelayed state did not follow");
  a_dly_wait: assert property (run0 && s.raw[0] != s.dly[0] && s.tmr[0] > 8'h01 |=> $stable(s.dly[0]))
    else $error("delayed state changed before expiry");
  a_revert: assert property (run0 && s.tmr[0] != 8'h00 && s.raw[0] == s.dly[0]
    |=> s.tmr[0] == 8'h00 ##0 $stable(s.dly[0]))
    else $error("reverted result did not stop timer");
  a_cyc_off: assert property (run0 && cyc_factor_i[0] == 8'h00 |=> s.cyc[0] == 15'h0000)
    else $error("cycle counter ran with factor zero");
  a_tel_perm: assert property (s.tv[0] |-> (s.tval[0] ? $past(tel_on_i[0]) : $past(tel_off_i[0])))
    else $error("telegram sent for a silent state");
  a_pct_write: assert property (run4 && ext_wr_i[4] && ext_mode_i[4] == lvh_pkg::EXT_PCT
    |=> s.thr[4] == 16'((24'($past(ext_val_i[7:0])) * 24'(lvh_pkg::HUM_RANGE)) >> 8))
    else $error("percentage threshold not taken");
  a_teach_one: assert property (run0 && ext_wr_i[0] && ext_mode_i[0] == lvh_pkg::EXT_TEACH && ext_val_i[0]
    |=> s.thr[0] == $past(co2_val_i))
    else $error("teach did not copy the measurement");
  a_dis_clear: assert property (s.loaded && !cfg_load_i && !ch_en_i[0] |=> !s.raw[0] && !s.dly[0])
    else $error("disabled channel kept its state");
  a_dis_quiet: assert property (!ch_en_i[0] |=> !s.tv[0])
    else $error("disabled channel sent a telegram");
  a_tv_value: assert property (s.tv[0] |-> s.tval[0] == s.dly[0])
    else $error("telegram value differs from delayed state");
  a_tval_hold: assert property (s.loaded |=> s.tv[0] || $stable(s.tval[0]))
    else $error("object value moved without a telegram");
  a_no_sample: assert property (run0 && !co2_valid_i |=> $stable(s.raw[0]))
    else $error("comparator moved without a sample");
  a_hum_eval: assert property (run4 && hum_valid_i && below_threshold_sets_on_i[4] && hum_val_i < s.thr[4]
    |=> s.raw[4])
    else $error("humidity sample not evaluated");
  a_opp_on: assert property (run1 && co2_valid_i && !below_threshold_sets_on_i[1] && co2_val_i > s.thr[1]
    |=> s.raw[1])
    else $error("exceed did not set comparator");
  a_equal_hold: assert property (run0 && co2_valid_i && below_threshold_sets_on_i[0] && co2_val_i == s.thr[0]
    |=> $stable(s.raw[0]))
    else $error("equal value changed comparator");
  a_tmr_load: assert property (run0 && s.raw[0] != s.dly[0] && s.tmr[0] == 8'h00
    && (s.raw[0] ? on_dly_i[0] : off_dly_i[0]) != 8'h00
    |=> s.tmr[0] == $past(s.raw[0] ? on_dly_i[0] : off_dly_i[0]))
    else $error("delay timer not loaded");
  a_cyc_keep: assert property (run0 && !s.tick |=> $stable(s.cyc[0]))
    else $error("cycle counter moved between ticks");
  a_cyc_wrap: assert property (run3 && s.tick && cyc_factor_i[3] == 8'h01 && s.raw[3] == s.dly[3]
    && s.cyc[3] == 15'(lvh_pkg::CYC_BASE_TICKS - 1) && (s.dly[3] ? tel_on_i[3] : tel_off_i[3])
    |=> s.tv[3])
    else $error("cyclic telegram missing at period end");
  a_load_clear: assert property (cfg_load_i |=> !s.raw[0] && !s.dly[0] && s.cyc[0] == 15'h0000)
    else $error("download did not clear channel state");

  c_ext_write: cover property (run0 && ext_wr_i[0] && ext_mode_i[0] == lvh_pkg::EXT_PCT);
  c_delayed: cover property (run0 && s.tmr[0] == 8'h01 && s.tick && s.raw[0] != s.dly[0]);
  c_cyclic: cover property (run0 && s.tick && cyc_factor_i[0] != 8'h00 && s.tv[0] ##1 s.tv[0]);
  c_teach: cover property (run4 && ext_wr_i[5] && ext_mode_i[5] == lvh_pkg::EXT_TEACH && ext_val_i[0]);
  c_silent: cover property (run3 && s.dly[3] && !tel_on_i[3] ##1 s.tick);
endmodule
`default_nettype wire

// ===== test/lvh_bus_rx.sv
`timescale 1ns/1ps
`default_nettype none
module lvh_bus_rx #(
  parameter int unsigned N = 6
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [N-1:0] tel_valid_i,
  input wire logic [N-1:0] tel_val_i,
  output logic [N-1:0][7:0] rx_cnt_o,
  output logic [N-1:0] rx_val_o,
  output logic [N-1:0][15:0] gap_o
);
  logic [31:0] now;
  logic [N-1:0][31:0] last;
  // Bus side never stalls, so every telegram pulse is taken in its own cycle
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      now <= '0;
      last <= '0;
      rx_cnt_o <= '0;
      rx_val_o <= '0;
      gap_o <= '0;
    end
    else
    begin
      now <= now + 32'h1;
      for (int i = 0; i < N; i++)
        if (tel_valid_i[i])
        begin
          rx_cnt_o[i] <= rx_cnt_o[i] + 8'h01;
          rx_val_o[i] <= tel_val_i[i];
          gap_o[i] <= 16'(now - last[i]);
          last[i] <= now;
        end
    end
  end
endmodule
`default_nettype wire

// ===== test/limit_value_hysteresis_monitor_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module limit_value_hysteresis_monitor_tb_top;
  localparam int N = 6;
  logic clk_i, rst_n_i, cfg_load_i, co2_valid_i, hum_valid_i;
  logic [15:0] co2_val_i, hum_val_i, ext_val_i;
  logic [N-1:0] ch_en, below, ton, toff, chg, ext_wr, tv, tval, rv;
  logic [N-1:0][15:0] thr, hyst, thr_o, gap;
  logic [N-1:0][7:0] cyc, ond, offd, cnt;
  logic [N-1:0][1:0] mode;
  logic [7:0] c3;
  int n_mismatch, num_checks;
  // Short tick keeps a cycle period at 400 clocks
  lvh_monitor #(.N_CO2(4), .N_HUM(2), .TICK_CYC(4)) lvh_monitor_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .cfg_load_i(cfg_load_i), .co2_val_i(co2_val_i),
    .co2_valid_i(co2_valid_i), .hum_val_i(hum_val_i), .hum_valid_i(hum_valid_i),
    .ch_en_i(ch_en), .cfg_thr_i(thr), .cfg_hyst_i(hyst), .below_threshold_sets_on_i(below),
    .tel_on_i(ton), .tel_off_i(toff), .chg_send_i(chg), .cyc_factor_i(cyc), .on_dly_i(ond),
    .off_dly_i(offd), .ext_mode_i(mode), .ext_wr_i(ext_wr), .ext_val_i(ext_val_i),
    .tel_valid_o(tv), .tel_val_o(tval), .threshold_level_o(thr_o));
  lvh_bus_rx #(.N(N)) lvh_bus_rx_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .tel_valid_i(tv),
    .tel_val_i(tval), .rx_cnt_o(cnt), .rx_val_o(rv), .gap_o(gap));
  task automatic complete_run();
    if (n_mismatch == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("ERROR %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic smp(input logic [15:0] v, input int w);
    @(posedge clk_i);
    co2_val_i <= v;
    co2_valid_i <= 1'b1;
    @(posedge clk_i);
    co2_valid_i <= 1'b0;
    repeat (w) @(posedge clk_i);
  endtask
  // Packed per channel 0..2 as {telegram count, last value}
  task automatic exp3(input logic [2:0][4:0] e);
    for (int i = 0; i < 3; i++)
      chk(16'({cnt[i][3:0], rv[i]}), 16'(e[i]));
  endtask
  // One clean write stands for a sender that fires only after a long press
  task automatic wr(input logic [N-1:0] m, input logic [15:0] v);
    @(posedge clk_i);
    ext_wr <= m;
    ext_val_i <= v;
    @(posedge clk_i);
    ext_wr <= '0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic thr_cfg();
    for (int i = 0; i < N; i++)
      chk(thr_o[i], thr[i]);
  endtask
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial
  begin
    n_mismatch = 0;
    num_checks = 0;
    rst_n_i = 1'b0;
    {cfg_load_i, co2_valid_i, hum_valid_i, co2_val_i, hum_val_i, ext_val_i, ext_wr} = '0;
    thr = {16'h0030, 16'h0020, {4{16'h0064}}};
    hyst = {80'h0, 16'h000A};
    {ch_en, ton, chg, below, toff} = {18'h3FFFF, 6'b111101, 6'b110111};
    cyc = {16'h0, 8'h01, 24'h0};
    ond = {24'h0, 8'h03, 16'h0};
    offd = '0;
    mode = {lvh_pkg::EXT_TEACH, lvh_pkg::EXT_PCT, 4'h0, lvh_pkg::EXT_ABS, lvh_pkg::EXT_NONE};
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    smp(16'h005A, 40);
    exp3({5'h03, 5'h00, 5'h03});
    repeat (1000) @(posedge clk_i);
    chk(gap[3], 16'h0190);
    smp(16'h0069, 40);
    exp3({5'h04, 5'h03, 5'h03});
    c3 = cnt[3];
    repeat (1000) @(posedge clk_i);
    chk(16'({cnt[3], rv[3]}), 16'({c3, 1'b1}));
    smp(16'h006F, 40);
    exp3({5'h04, 5'h03, 5'h04});
    smp(16'h005F, 500);
    exp3({5'h07, 5'h04, 5'h07});
    chk(16'(rv[3] && (cnt[3] - c3 >= 8'h02)), 16'h0001);
    smp(16'h0069, 40);
    exp3({5'h08, 5'h07, 5'h07});
    smp(16'h005A, 2);
    smp(16'h006E, 40);
    exp3({5'h08, 5'h0B, 5'h07});
    thr_cfg();
    @(posedge clk_i);
    hum_val_i <= 16'h0041;
    hum_valid_i <= 1'b1;
    @(posedge clk_i);
    hum_valid_i <= 1'b0;
    wr(6'b000011, 16'h0050);
    wr(6'b010000, 16'h0080);
    wr(6'b100000, 16'h0000);
    chk(thr_o[5], thr[5]);
    wr(6'b100000, 16'h0001);
    chk(thr_o[0], thr[0]);
    chk(thr_o[1], 16'h0050);
    chk(thr_o[4], 16'h0032);
    chk(thr_o[5], 16'h0041);
    @(posedge clk_i);
    cfg_load_i <= 1'b1;
    @(posedge clk_i);
    cfg_load_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    thr_cfg();
    complete_run();
  end
endmodule
`default_nettype wire
